// ---- hw/polar_pkg.sv ----
// Constants, widths and the arctangent table of the Cartesian to polar converter
package polar_pkg;

  localparam int IQ_W       = 16;  // In-phase and quadrature width
  localparam int PH_W       = 18;  // Full phase width
  localparam int PH_OUT_W   = 16;  // Short phase width
  localparam int MAG_W      = 16;  // Magnitude width
  localparam int GUARD      = 2;   // Fractional guard bits in the datapath
  localparam int EXT        = 4;   // Integer headroom bits for vector growth
  localparam int INT_W      = IQ_W + GUARD + EXT;
  localparam int MAG_LSB    = 4;   // Datapath bit that maps to magnitude bit 0
  localparam int FULL_STEPS = 17;  // Quadrant step plus sixteen rotations
  localparam int STEP_W     = 5;   // Width of the step counter
  localparam int BUF_DEPTH  = 2;   // Entries of the holding buffer
  localparam int CLK_PERIOD_NS = 20;

  localparam logic [PH_W-1:0] HALF_TURN = 18'h20000;
  localparam logic [PH_W-1:0] ZERO_TURN = 18'h00000;

  // Arctangent of two to the minus idx, in turns scaled by two to the 18
  function automatic logic [PH_W-1:0] atan_turns(input logic [3:0] idx);
    logic [PH_W-1:0] v;
    v = 18'h00000;
    case (idx)
      4'h0: v = 18'h08000;
      4'h1: v = 18'h04b90;
      4'h2: v = 18'h027ed;
      4'h3: v = 18'h01444;
      4'h4: v = 18'h00a2c;
      4'h5: v = 18'h00517;
      4'h6: v = 18'h0028c;
      4'h7: v = 18'h00146;
      4'h8: v = 18'h000a3;
      4'h9: v = 18'h00051;
      4'ha: v = 18'h00029;
      4'hb: v = 18'h00014;
      4'hc: v = 18'h0000a;
      4'hd: v = 18'h00005;
      4'he: v = 18'h00003;
      4'hf: v = 18'h00001;
      default: v = 18'h00000;
    endcase
    return v;
  endfunction : atan_turns

endpackage : polar_pkg

// ---- hw/hold_buffer.sv ----
// Small shift-type buffer that holds latched results for the downstream stage
`timescale 1ns/1ps
`default_nettype none
module hold_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int CNT_W = $clog2(DEPTH + 1);

  // Shape check, refused at elaboration
  if (DEPTH < 2 || W < 1) begin : g_bad_shape
    $error("hold_buffer needs at least two entries and one bit");
  end

  logic [W-1:0]     mem_q [DEPTH];
  logic [W-1:0]     mem_d [DEPTH];
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] wr_idx;
  logic             push;
  logic             pop;

  // Honest flags: ready only with a free entry, valid only with a stored one
  assign in_ready  = (cnt_q < CNT_W'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Head leaves by shifting down; new entry lands behind the last kept one
  always_comb begin
    wr_idx = pop ? cnt_q - CNT_W'(1) : cnt_q;
    for (int k = 0; k < DEPTH; k++) begin
      mem_d[k] = mem_q[k];
    end
    if (pop) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        mem_d[k] = mem_q[k+1];
      end
    end
    for (int k = 0; k < DEPTH; k++) begin
      if (push && CNT_W'(k) == wr_idx) begin
        mem_d[k] = in_data;
      end
    end
    cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
  end

  // Entry and count registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= mem_d[k];
      end
    end
  end

endmodule : hold_buffer
`default_nettype wire

// ---- hw/polar_converter.sv ----
// Iterative Cartesian to polar converter with partial-result latching
`timescale 1ns/1ps
`default_nettype none
module polar_converter
  import polar_pkg::*;
#(
  parameter int STEPS = FULL_STEPS
) (
  input  wire logic                MCLK,
  input  wire logic                NRST,
  input  wire logic                IN_VALID,
  output logic                     IN_READY,
  input  wire logic [IQ_W-1:0]     IN_I,
  input  wire logic [IQ_W-1:0]     IN_Q,
  output logic                     OUT_VALID,
  input  wire logic                OUT_READY,
  output logic [MAG_W-1:0]         OUT_MAG,
  output logic [PH_OUT_W-1:0]      OUT_PHASE,
  output logic [PH_W-1:0]          OUT_PHASE_FULL,
  output logic [STEP_W-1:0]        OUT_STEPS,
  output logic                     BUSY
);

  localparam int BUF_W = MAG_W + PH_W + STEP_W;

  // Step count must fit the arctangent table and the counter
  if (STEPS < 1 || STEPS > FULL_STEPS) begin : g_bad_steps
    $error("polar_converter STEPS must lie between 1 and 17");
  end

  // Counter must reach the full step count, or completion would never be seen
  if ((1 << STEP_W) <= FULL_STEPS) begin : g_bad_counter
    $error("polar_converter step counter too narrow");
  end

  // Magnitude field must sit inside the datapath word
  if (MAG_LSB + MAG_W > INT_W) begin : g_bad_mag
    $error("polar_converter magnitude field outside the datapath");
  end

  // Short phase is a slice of the full phase
  if (PH_OUT_W > PH_W) begin : g_bad_phase
    $error("polar_converter short phase wider than full phase");
  end

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } run_state_e;

  run_state_e               state_q;
  run_state_e               state_d;
  logic [STEP_W-1:0]        step_q;
  logic [STEP_W-1:0]        step_d;
  logic signed [INT_W-1:0]  x_q;
  logic signed [INT_W-1:0]  x_d;
  logic signed [INT_W-1:0]  y_q;
  logic signed [INT_W-1:0]  y_d;
  logic [PH_W-1:0]          z_q;
  logic [PH_W-1:0]          z_d;

  logic signed [INT_W-1:0]  x_nx;
  logic signed [INT_W-1:0]  y_nx;
  logic [PH_W-1:0]          z_nx;
  logic signed [INT_W-1:0]  x_sh;
  logic signed [INT_W-1:0]  y_sh;
  logic signed [INT_W-1:0]  x_abs;
  logic [STEP_W-1:0]        iter;
  logic [STEP_W-1:0]        last_step;

  logic                     take;
  logic                     last;
  logic                     advance;
  logic                     finish;
  logic                     preempt;

  logic                     buf_in_valid;
  logic                     buf_in_ready;
  logic [BUF_W-1:0]         buf_in_data;
  logic [BUF_W-1:0]         buf_out_data;
  logic [MAG_W-1:0]         res_mag;
  logic [PH_W-1:0]          res_ph;
  logic [STEP_W-1:0]        res_steps;

  // Sample acceptance; a busy engine may only be preempted if the buffer has room
  assign last_step = STEP_W'(STEPS - 1);
  assign IN_READY  = (state_q == ST_IDLE) || buf_in_ready;
  assign take      = IN_VALID && IN_READY;
  assign last      = (state_q == ST_RUN) && (step_q == last_step);
  assign preempt   = take && (state_q == ST_RUN);
  assign finish    = last && buf_in_ready && !preempt;
  assign advance   = (state_q == ST_RUN) && (!last || buf_in_ready);
  assign BUSY      = (state_q == ST_RUN);

  // One refinement step: quadrant fold first, then shift-and-add rotations
  always_comb begin
    iter = step_q - STEP_W'(1);
    x_sh = x_q >>> iter;
    y_sh = y_q >>> iter;
    x_nx = x_q;
    y_nx = y_q;
    z_nx = z_q;
    if (step_q == '0) begin
      // Left half plane is folded by a half turn so rotations converge
      if (x_q < 0) begin
        x_nx = -x_q;
        y_nx = -y_q;
        z_nx = HALF_TURN;
      end else begin
        z_nx = ZERO_TURN;
      end
    end else if (y_q >= 0) begin
      x_nx = x_q + y_sh;
      y_nx = y_q - x_sh;
      z_nx = z_q + atan_turns(iter[3:0]);
    end else begin
      x_nx = x_q - y_sh;
      y_nx = y_q + x_sh;
      z_nx = z_q - atan_turns(iter[3:0]);
    end
  end

  // Engine next state: load on every accepted sample, else refine one step unless the last step waits for buffer room
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    x_d     = x_q;
    y_d     = y_q;
    z_d     = z_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (finish) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (take) begin
      // Sign-extended operands with guard bits below the input LSB
      x_d    = {{EXT{IN_I[IQ_W-1]}}, IN_I, {GUARD{1'b0}}};
      y_d    = {{EXT{IN_Q[IQ_W-1]}}, IN_Q, {GUARD{1'b0}}};
      z_d    = ZERO_TURN;
      step_d = '0;
    end else if (advance) begin
      x_d    = x_nx;
      y_d    = y_nx;
      z_d    = z_nx;
      step_d = step_q + STEP_W'(1);
    end
  end

  // Engine registers
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      step_q  <= '0;
      x_q     <= '0;
      y_q     <= '0;
      z_q     <= '0;
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      x_q     <= x_d;
      y_q     <= y_d;
      z_q     <= z_d;
    end
  end

  // Result selection: partial state on preemption, final step on completion
  always_comb begin
    x_abs     = (x_q < 0) ? -x_q : x_q;
    res_mag   = x_abs[MAG_LSB+MAG_W-1:MAG_LSB];
    res_ph    = z_q;
    res_steps = step_q;
    if (!preempt) begin
      res_mag   = x_nx[MAG_LSB+MAG_W-1:MAG_LSB];
      res_ph    = z_nx;
      res_steps = STEP_W'(STEPS);
    end
    res_mag[MAG_W-1] = 1'b0;
  end

  // Latch request toward the holding buffer
  assign buf_in_valid = preempt || finish;
  assign buf_in_data  = {res_steps, res_ph, res_mag};

  // Holding buffer: magnitude and phase travel as one word
  hold_buffer #(
    .W     (BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_hold (
    .clk       (MCLK),
    .rst_n     (NRST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (buf_out_data)
  );

  // Unpack the held word; the short phase is the top bits of the full phase in it
  assign OUT_MAG        = buf_out_data[MAG_W-1:0];
  assign OUT_PHASE_FULL = buf_out_data[MAG_W+PH_W-1:MAG_W];
  assign OUT_PHASE      = buf_out_data[MAG_W+PH_W-1:MAG_W+PH_W-PH_OUT_W];
  assign OUT_STEPS      = buf_out_data[BUF_W-1:MAG_W+PH_W];

endmodule : polar_converter
`default_nettype wire

// ---- tb/polar_props.sv ----
// Concurrent checks on the converter ports
`timescale 1ns/1ps
`default_nettype none
module polar_props
  import polar_pkg::*;
#(
  parameter int STEPS = FULL_STEPS
) (
  input wire logic                MCLK,
  input wire logic                NRST,
  input wire logic                IN_VALID,
  input wire logic                IN_READY,
  input wire logic [IQ_W-1:0]     IN_I,
  input wire logic [IQ_W-1:0]     IN_Q,
  input wire logic                OUT_VALID,
  input wire logic                OUT_READY,
  input wire logic [MAG_W-1:0]    OUT_MAG,
  input wire logic [PH_OUT_W-1:0] OUT_PHASE,
  input wire logic [PH_W-1:0]     OUT_PHASE_FULL,
  input wire logic [STEP_W-1:0]   OUT_STEPS,
  input wire logic                BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Sample accepted by the engine
  wire take = IN_VALID && IN_READY;

  chk_mag_msb: assert property (OUT_VALID |-> OUT_MAG[15] == 1'b0)
    else $error("magnitude top bit set");
  chk_phase_top: assert property (OUT_PHASE == OUT_PHASE_FULL[17:2])
    else $error("short phase differs from full phase");
  chk_hold_data: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_MAG) && $stable(OUT_PHASE_FULL))
    else $error("held result changed");
  chk_hold_steps: assert property (OUT_VALID && !OUT_READY |=> $stable(OUT_STEPS))
    else $error("held step count changed");
  chk_steps_cap: assert property (OUT_VALID |-> OUT_STEPS <= STEPS)
    else $error("step count too large");
  chk_busy_start: assert property (take |=> BUSY)
    else $error("engine idle after take");
  chk_preempt_latch: assert property (take && BUSY |=> OUT_VALID)
    else $error("partial result not latched");
  chk_done_latch: assert property ($fell(BUSY) |-> OUT_VALID)
    else $error("finished result not latched");
  chk_refuse_full: assert property (!IN_READY |-> BUSY && OUT_VALID)
    else $error("input refused without cause");
endmodule : polar_props
bind polar_converter polar_props #(.STEPS(STEPS)) u_props (.MCLK(MCLK), .NRST(NRST), .IN_VALID(IN_VALID),
  .IN_READY(IN_READY), .IN_I(IN_I), .IN_Q(IN_Q), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_MAG(OUT_MAG),
  .OUT_PHASE(OUT_PHASE), .OUT_PHASE_FULL(OUT_PHASE_FULL), .OUT_STEPS(OUT_STEPS), .BUSY(BUSY));
`default_nettype wire

// ---- tb/ready_sink.sv ----
// Downstream stage model that takes results with random stalls
`timescale 1ns/1ps
`default_nettype none
module ready_sink (
  input  wire logic clk,
  input  wire logic stall,
  output logic      ready
);
  logic [7:0] lfsr_q  = 8'h5a;
  logic       ready_q = 1'b0;
  // Pseudo-random acceptance, forced off while stalled
  always @(negedge clk) begin
    lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    ready_q <= !stall && (lfsr_q[1:0] != 2'h0);
  end
  assign ready = ready_q;
endmodule : ready_sink
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the polar converter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import polar_pkg::*;
  typedef struct {real m; real p; int s;} note_s;
  logic                mclk = 0, nrst = 0, in_valid = 0, stall = 0;
  logic                out_ready, out_valid, in_ready, busy;
  logic [IQ_W-1:0]     in_i = '0, in_q = '0;
  logic [MAG_W-1:0]    out_mag;
  logic [PH_OUT_W-1:0] out_phase;
  logic [PH_W-1:0]     out_full;
  logic [STEP_W-1:0]   out_steps;
  note_s               notes[$];
  int                  err_count = 0, samples_checked = 0, cyc = 0, last = -99;
  int                  ti[6] = '{16384, 0, -16384, 0, 11585, -11585};
  int                  tq[6] = '{0, 16384, 0, -16384, 11585, -11585};

  initial forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  polar_converter dut (.MCLK(mclk), .NRST(nrst), .IN_VALID(in_valid), .IN_READY(in_ready), .IN_I(in_i),
    .IN_Q(in_q), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_MAG(out_mag), .OUT_PHASE(out_phase),
    .OUT_PHASE_FULL(out_full), .OUT_STEPS(out_steps), .BUSY(busy));
  ready_sink sink (.clk(mclk), .stall(stall), .ready(out_ready));

  task end_sim;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task chk(input string nm, input real e, input real s, input real t);
    samples_checked++;
    if (s - e > t || e - s > t) begin
      err_count++;
      $display("wrong value %s expected %f seen %f", nm, e, s);
    end
  endtask : chk

  // Components of 8192..16383 in size keep vectors long enough for the fine phase checks
  function automatic int rnd();
    int v;
    v = 8192 + int'($urandom_range(8191));
    return ($urandom_range(1) == 1) ? v : -v;
  endfunction : rnd

  // Offer one sample, note its expected result, then leave a gap of k cycles to the next take
  task send(input int i, input int q, input int k);
    real p;
    @(negedge mclk);
    in_valid = 1;
    in_i = i[15:0];
    in_q = q[15:0];
    repeat (100) if (!in_ready) @(negedge mclk);
    if (!in_ready) begin
      err_count++;
      end_sim();
    end
    @(posedge mclk);
    // A preempted sample has done one step fewer than the gap to the next take
    if (cyc - last < 18 && notes.size() > 0) notes[$].s = cyc - last - 1;
    last = cyc;
    p = $atan2(q, i) / 6.283185307;
    if (p < 0) p += 1.0;
    notes.push_back('{1.64676 * $sqrt(i * i + q * q) / 4.0, p * 262144.0, 17});
    if (k > 1) begin
      @(negedge mclk);
      in_valid = 0;
      repeat (k - 1) @(posedge mclk);
    end
  endtask : send

  // Compare each result leaving the buffer with the oldest note
  always @(posedge mclk) begin
    if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
      note_s n;
      real d;
      if (notes.size() == 0) begin
        err_count++;
        $display("wrong value result expected none seen %h", out_mag);
      end else begin
        n = notes.pop_front();
        chk("steps", n.s, out_steps, 0.0);
        if (out_steps !== n.s[4:0]) begin
          err_count++;
          $display("wrong value steps_bits expected %0d seen %b", n.s, out_steps);
        end
        if (n.s >= 6) begin
          d = real'(out_full) - n.p;
          if (d > 131072.0) d -= 262144.0;
          if (d < -131072.0) d += 262144.0;
          chk("phase", 0.0, d, 8.0 + 5100.0 / (2.0 ** (n.s - 6)));
          chk("magnitude", n.m, out_mag, 8.0 + n.m * 0.004 / (2.0 ** (n.s - 6)));
          d = real'(out_phase) - n.p / 4.0;
          if (d > 32768.0) d -= 65536.0;
          if (d < -32768.0) d += 65536.0;
          chk("short phase", 0.0, d, 3.0 + 1275.0 / (2.0 ** (n.s - 6)));
        end
      end
    end
  end

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(37360));
    repeat (8) @(negedge mclk);
    nrst = 1;
    // Full conversions on axes and diagonals
    for (int j = 0; j < 6; j++) send(ti[j], tq[j], 20);
    // Random vectors at every preemption distance, back to back first
    for (int k = 1; k <= 19; k++) send(rnd(), rnd(), k);
    // Let the buffer drain, fill it while downstream stalls, then release it
    repeat (100) if (notes.size() != 0) @(negedge mclk);
    @(negedge mclk);
    stall = 1;
    repeat (3) send(rnd(), rnd(), 20);
    @(negedge mclk);
    chk("in_ready", 0.0, (in_ready === 1'b0) ? 0.0 : 1.0, 0.0);
    stall = 0;
    repeat (200) if (notes.size() != 0) @(posedge mclk);
    chk("pending", 0.0, notes.size(), 0.0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
